// [src/udmab_pkg.sv]
// Purpose: Shared constants, CRC step and mode codes for the burst link
// Assumes: core_clk at 200 MHz; 16-bit burst data
// Notes:   Times kept in ps; cycle counts derive from them
package udmab_pkg;

  // ----------------------------------------------------------------
  // Interface modes and transfer modes
  // ----------------------------------------------------------------
  localparam logic [1:0] IFM_MEM       = 2'h0;
  localparam logic [1:0] IFM_IO        = 2'h1;
  localparam logic [1:0] IFM_IDE       = 2'h2;
  localparam logic [2:0] UDMA_MODE_MAX = 3'h4;
  localparam logic [2:0] MODE_NONE     = 3'h7;
  localparam int         ID_SEL_LSB    = 8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PS    = 5000;
  localparam int T_CYC_PS  = 25000;
  localparam int T_DVS_PS  = 6700;
  localparam int CYC_CNT   = (T_CYC_PS + CLK_PS - 1) / CLK_PS;
  localparam int DVS_CNT   = (T_DVS_PS + CLK_PS - 1) / CLK_PS;
  localparam logic [2:0] PH_LAST = 3'(CYC_CNT - 1);
  localparam logic [2:0] PH_DVS  = 3'(DVS_CNT);

  // ----------------------------------------------------------------
  // Burst CRC
  // ----------------------------------------------------------------
  localparam logic [15:0] CRC_INIT = 16'h4ABA;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] BUS_IDLE = 16'hFFFF;
  localparam logic [10:0] ADDR_UDMA = 11'h000;

  function automatic logic [15:0] udmab_crc(input logic [15:0] c, input logic [15:0] w);
    logic [15:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ w[i]) ? CRC_POLY : 16'h0000);
    end
    return r;
  endfunction : udmab_crc

endpackage : udmab_pkg

// [src/udmab_if.sv]
// Purpose: Pin bundle between card end and host end
// Assumes: Pins carry physical levels; data bus resolved here
// Notes:   Undriven data bus reads as pulled up
`timescale 1ns/1ps
interface udmab_if;
  logic        dmarq;
  logic        dmack;
  logic        stop;
  logic        hrdy_hstb;
  logic        drdy_dstb;
  logic        intrq;
  logic [15:0] dev_d_o;
  logic        dev_d_oe_n;
  logic [15:0] host_d_o;
  logic        host_d_oe_n;
  logic [15:0] d;
  logic [10:0] addr;
  logic [1:0]  cs_n;

  assign d = !dev_d_oe_n ? dev_d_o : (!host_d_oe_n ? host_d_o : 16'hFFFF);

  modport dev (output dmarq, drdy_dstb, intrq, dev_d_o, dev_d_oe_n,
               input dmack, stop, hrdy_hstb, d, addr, cs_n);
  modport host (output dmack, stop, hrdy_hstb, host_d_o, host_d_oe_n, addr, cs_n,
                input dmarq, drdy_dstb, intrq, d);
endinterface : udmab_if

// [src/udmab_device.sv]
// Purpose: Card end of the burst link: request, data, CRC check, mode
// Assumes: Host keeps its own pin rules; link inputs are asynchronous
// Notes:   One command may need several bursts; CRC checked per burst
//
// What this block does
// - Read/write DMA moves data only by bursts
// - Burst meanings need mode, command, request, acknowledge
// - Lines revert when acknowledge drops
// - Host line: ready or strobe; card line likewise
// - Every strobe edge carries one word
// - Data driver also drives the strobe
// - Data first, strobe edge after setup
// - Identify word shows supported and chosen modes
// - Host picks one mode, not above fastest
// - Supporting a mode means supporting slower ones
// - Soft reset keeps mode if reverting disabled
// - Hardware reset clears selected mode
// - Host sends CRC; card compares and flags
// - Report the first error of a command
// - On CRC error finish transfer, still report
// - Host keeps selects negated, address stable
// - Fixed-disk mode: low address lines zero
// - Host writes no task file during command
// - Burst words are always 16 bits
// - Host makes no space access during bursts
// - Memory mode: no attribute access during command
// - Burst spans acknowledge assert to negate
// - Memory mode: ready busy for whole command
`timescale 1ns/1ps
module udmab_device
  import udmab_pkg::*;
#(
  parameter logic [2:0] MAX_MODE = UDMA_MODE_MAX
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Link pins
  udmab_if.dev             link,
  // Configuration
  input  wire logic [1:0]  iface_mode,
  input  wire logic        feat_mode_stb,
  input  wire logic [2:0]  feat_mode_val,
  input  wire logic        feat_revert_dis_stb,
  input  wire logic        feat_revert_en_stb,
  input  wire logic        soft_rst,
  // Command
  input  wire logic        cmd_stb,
  input  wire logic        cmd_write,
  input  wire logic [15:0] cmd_words,
  // Data
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_valid,
  output logic             tx_take,
  output logic [15:0]      rx_data,
  output logic             rx_valid,
  // Status
  output logic [15:0]      id_udma_word,
  output logic [2:0]       udma_mode,
  output logic             cmd_busy,
  output logic             cmd_done,
  output logic             mdma_fallback,
  output logic             crc_err,
  output logic [15:0]      err_left
);

  typedef enum logic [2:0] {ST_IDLE, ST_REQ, ST_XFER, ST_TERM} udmab_dstate_t;

  if (MAX_MODE > UDMA_MODE_MAX || DVS_CNT >= CYC_CNT || CYC_CNT > 8) begin : g_chk
    $error("udmab_device: unsupported mode or timing");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [18:0] sy1;
  logic [18:0] sy2;
  logic        hs3;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sy1 <= 19'h00000;
      sy2 <= 19'h00000;
      hs3 <= 1'b1;
    end else begin
      sy1 <= {link.dmack, link.stop, link.hrdy_hstb, link.d};
      sy2 <= sy1;
      hs3 <= sy2[16];
    end
  end

  logic        dmack_act;
  logic        stop_s;
  logic        hs_s;
  logic        hrdy_act;
  logic [15:0] d_s;

  assign dmack_act = (iface_mode == IFM_IO) ? sy2[18] : ~sy2[18];
  assign stop_s    = sy2[17];
  assign hs_s      = sy2[16];
  assign hrdy_act  = ~sy2[16];
  assign d_s       = sy2[15:0];

  // ----------------------------------------------------------------
  // Burst control
  // ----------------------------------------------------------------
  udmab_dstate_t state, next_state;
  logic [2:0]  next_mode;
  logic        rev_dis, next_rev_dis;
  logic        is_wr, next_wr;
  logic [15:0] left, next_left;
  logic [15:0] crc, next_crc;
  logic        irq, next_irq;
  logic [2:0]  ph, next_ph;
  logic        dstb, next_dstb;
  logic [15:0] dout, next_dout;
  logic        doe_n, next_doe_n;
  logic        dmarq_pin, next_dmarq_pin;
  logic        drdy_pin, next_drdy_pin;
  logic        intrq_pin, next_intrq_pin;
  logic        next_tx_take, next_rx_valid, next_done, next_busy, next_fb, next_err, next_rq;
  logic [15:0] next_rx_data, next_err_left, next_id;

  always_comb begin
    next_state     = state;
    next_mode      = udma_mode;
    next_rev_dis   = rev_dis;
    next_wr        = is_wr;
    next_left      = left;
    next_crc       = crc;
    next_irq       = irq;
    next_ph        = ph;
    next_dstb      = dstb;
    next_dout      = dout;
    next_doe_n     = doe_n;
    next_busy      = cmd_busy;
    next_fb        = mdma_fallback;
    next_err       = crc_err;
    next_err_left  = err_left;
    next_rx_data   = rx_data;
    next_rx_valid  = 1'b0;
    next_tx_take   = 1'b0;
    next_done      = 1'b0;

    // Slower modes are always acceptable; faster ones are ignored
    if (feat_mode_stb && feat_mode_val <= MAX_MODE) begin
      next_mode = feat_mode_val;
    end
    if (feat_revert_dis_stb) begin
      next_rev_dis = 1'b1;
    end
    if (feat_revert_en_stb) begin
      next_rev_dis = 1'b0;
    end

    unique case (state)
      ST_IDLE: begin
        if (cmd_stb) begin
          next_irq = 1'b0;
          next_fb  = 1'b0;
          if (udma_mode == MODE_NONE) begin
            next_fb = 1'b1;
          end else if (cmd_words != 16'h0000) begin
            next_state = ST_REQ;
            next_busy  = 1'b1;
            next_err   = 1'b0;
            next_err_left = 16'h0000;
            next_wr    = cmd_write;
            next_left  = cmd_words;
          end
        end
      end
      ST_REQ: begin
        if (dmack_act) begin
          next_state = ST_XFER;
          next_crc   = CRC_INIT;
          next_ph    = 3'h0;
          next_dstb  = 1'b1;
          next_doe_n = is_wr;
        end
      end
      ST_XFER: begin
        if (stop_s || (left == 16'h0000 && ph == 3'h0)) begin
          // Bus freed at once so the host can place its CRC
          next_state = ST_TERM;
          next_doe_n = 1'b1;
          next_dstb  = 1'b1;
        end else if (!is_wr) begin
          if (ph == 3'h0) begin
            if (hrdy_act && tx_valid) begin
              next_dout    = tx_data;
              next_tx_take = 1'b1;
              next_crc     = udmab_crc(crc, tx_data);
              next_ph      = 3'h1;
            end
          end else begin
            if (ph == PH_DVS) begin
              next_dstb = ~dstb;
              next_left = left - 16'h0001;
            end
            next_ph = (ph == PH_LAST) ? 3'h0 : ph + 3'h1;
          end
        end else if (hs_s != hs3) begin
          next_rx_data  = d_s;
          next_rx_valid = 1'b1;
          next_crc      = udmab_crc(crc, d_s);
          next_left     = left - 16'h0001;
        end
      end
      ST_TERM: begin
        if (!dmack_act) begin
          if (d_s != crc && !crc_err) begin
            next_err      = 1'b1;
            next_err_left = left;
          end
          // A CRC error does not cut the command short
          if (left == 16'h0000) begin
            next_state = ST_IDLE;
            next_busy  = 1'b0;
            next_irq   = 1'b1;
            next_done  = 1'b1;
          end else begin
            next_state = ST_REQ;
          end
        end
      end
    endcase

    if (soft_rst) begin
      if (!rev_dis) begin
        next_mode = MODE_NONE;
      end
      next_state = ST_IDLE;
      next_busy  = 1'b0;
      next_doe_n = 1'b1;
    end

    for (int i = 0; i < 8; i++) begin
      next_id[i]              = (3'(i) <= MAX_MODE);
      next_id[ID_SEL_LSB + i] = (next_mode == 3'(i)) && (next_mode != MODE_NONE);
    end

    // Reset goes through here for the request and interrupt pins: their idle level depends on the mode
    next_rq        = !rst && (next_state == ST_REQ || next_state == ST_XFER);
    next_dmarq_pin = (iface_mode == IFM_IDE) ? next_rq : !next_rq;
    next_drdy_pin  = (next_state == ST_XFER) ? (next_wr ? 1'b0 : next_dstb) : 1'b1;
    unique case (iface_mode)
      IFM_MEM: next_intrq_pin = rst || !next_busy;
      IFM_IO:  next_intrq_pin = rst || !next_irq;
      default: next_intrq_pin = !rst && next_irq;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state         <= ST_IDLE;
      udma_mode     <= MODE_NONE;
      rev_dis       <= 1'b0;
      is_wr         <= 1'b0;
      left          <= 16'h0000;
      crc           <= CRC_INIT;
      irq           <= 1'b0;
      ph            <= 3'h0;
      dstb          <= 1'b1;
      dout          <= 16'h0000;
      doe_n         <= 1'b1;
      cmd_busy      <= 1'b0;
      mdma_fallback <= 1'b0;
      crc_err       <= 1'b0;
      err_left      <= 16'h0000;
      rx_data       <= 16'h0000;
      rx_valid      <= 1'b0;
      tx_take       <= 1'b0;
      cmd_done      <= 1'b0;
      id_udma_word  <= 16'h0000;
      drdy_pin      <= 1'b1;
    end else begin
      state         <= next_state;
      udma_mode     <= next_mode;
      rev_dis       <= next_rev_dis;
      is_wr         <= next_wr;
      left          <= next_left;
      crc           <= next_crc;
      irq           <= next_irq;
      ph            <= next_ph;
      dstb          <= next_dstb;
      dout          <= next_dout;
      doe_n         <= next_doe_n;
      cmd_busy      <= next_busy;
      mdma_fallback <= next_fb;
      crc_err       <= next_err;
      err_left      <= next_err_left;
      rx_data       <= next_rx_data;
      rx_valid      <= next_rx_valid;
      tx_take       <= next_tx_take;
      cmd_done      <= next_done;
      id_udma_word  <= next_id;
      drdy_pin      <= next_drdy_pin;
    end
    dmarq_pin <= next_dmarq_pin;
    intrq_pin <= next_intrq_pin;
  end

  assign link.dmarq      = dmarq_pin;
  assign link.drdy_dstb  = drdy_pin;
  assign link.intrq      = intrq_pin;
  assign link.dev_d_o    = dout;
  assign link.dev_d_oe_n = doe_n;

endmodule : udmab_device

// [src/udmab_host.sv]
// Purpose: Host end of the burst link: acknowledge, data, CRC send
// Assumes: Card end keeps its own pin rules; link inputs asynchronous
// Notes:   Host user supplies exactly the words the command needs
`timescale 1ns/1ps
module udmab_host
  import udmab_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Link pins
  udmab_if.host            link,
  // Configuration
  input  wire logic [1:0]  iface_mode,
  input  wire logic [15:0] dev_id_word,
  input  wire logic [2:0]  sel_mode,
  input  wire logic        cmd_write,
  // Data
  input  wire logic [15:0] tx_data,
  input  wire logic        tx_valid,
  output logic             tx_take,
  output logic [15:0]      rx_data,
  output logic             rx_valid,
  // Status
  output logic             mode_ok,
  output logic             burst_done
);

  typedef enum logic [2:0] {H_IDLE, H_XFER, H_STOP, H_CRC} udmab_hstate_t;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [17:0] sy1;
  logic [17:0] sy2;
  logic        ds3;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sy1 <= 18'h00000;
      sy2 <= 18'h00000;
      ds3 <= 1'b1;
    end else begin
      sy1 <= {link.dmarq, link.drdy_dstb, link.d};
      sy2 <= sy1;
      ds3 <= sy2[16];
    end
  end

  logic dmarq_act;
  assign dmarq_act = (iface_mode == IFM_IDE) ? sy2[17] : ~sy2[17];

  // ----------------------------------------------------------------
  // Burst control
  // ----------------------------------------------------------------
  udmab_hstate_t state, next_state;
  logic        is_wr, next_wr, ack, next_ack, stp, next_stp;
  logic        hl, next_hl, hoe_n, next_hoe_n, next_ok;
  logic        next_take, next_rxv, next_done;
  logic [2:0]  ph, next_ph;
  logic [15:0] crc, next_crc, hout, next_hout, next_rxd;
  logic        dmack_pin, next_dmack_pin;

  always_comb begin
    next_state = state;
    next_wr    = is_wr;
    next_ack   = ack;
    next_stp   = stp;
    next_hl    = hl;
    next_hoe_n = hoe_n;
    next_ph    = ph;
    next_crc   = crc;
    next_hout  = hout;
    next_rxd   = rx_data;
    next_rxv   = 1'b0;
    next_take  = 1'b0;
    next_done  = 1'b0;
    next_ok    = (sel_mode <= UDMA_MODE_MAX) && dev_id_word[sel_mode];

    unique case (state)
      H_IDLE: begin
        if (dmarq_act && mode_ok) begin
          next_state = H_XFER;
          next_ack   = 1'b1;
          next_wr    = cmd_write;
          next_hl    = cmd_write;       // Ready low for reads, strobe high for writes
          next_hoe_n = !cmd_write;
          next_crc   = CRC_INIT;
          next_ph    = 3'h0;
        end
      end
      H_XFER: begin
        if (!dmarq_act && ph == 3'h0) begin
          next_state = H_STOP;
          next_stp   = 1'b1;
          next_hl    = 1'b1;
          next_hout  = crc;
          next_hoe_n = 1'b0;
          next_ph    = 3'h0;
        end else if (!is_wr) begin
          if (sy2[16] != ds3 && dmarq_act) begin
            next_rxd = sy2[15:0];
            next_rxv = 1'b1;
            next_crc = udmab_crc(crc, sy2[15:0]);
          end
        end else if (ph == 3'h0) begin
          if (!sy2[16] && dmarq_act && tx_valid) begin
            next_hout = tx_data;
            next_take = 1'b1;
            next_crc  = udmab_crc(crc, tx_data);
            next_ph   = 3'h1;
          end
        end else begin
          if (ph == PH_DVS) begin
            next_hl = ~hl;
          end
          next_ph = (ph == PH_LAST) ? 3'h0 : ph + 3'h1;
        end
      end
      H_STOP: begin
        // CRC settles before the acknowledge drops
        next_ph = ph + 3'h1;
        if (ph == PH_DVS) begin
          next_state = H_CRC;
          next_ack   = 1'b0;
          next_ph    = 3'h0;
        end
      end
      H_CRC: begin
        next_ph = ph + 3'h1;
        if (ph == PH_LAST) begin
          next_state = H_IDLE;
          next_stp   = 1'b0;
          next_hoe_n = 1'b1;
          next_done  = 1'b1;
        end
      end
    endcase
    // Reset goes through here: the idle level of the pin depends on the mode
    next_dmack_pin = (iface_mode == IFM_IO) ? (next_ack && !rst) : !(next_ack && !rst);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state      <= H_IDLE;
      is_wr      <= 1'b0;
      ack        <= 1'b0;
      stp        <= 1'b0;
      hl         <= 1'b1;
      hoe_n      <= 1'b1;
      ph         <= 3'h0;
      crc        <= CRC_INIT;
      hout       <= 16'h0000;
      rx_data    <= 16'h0000;
      rx_valid   <= 1'b0;
      tx_take    <= 1'b0;
      burst_done <= 1'b0;
      mode_ok    <= 1'b0;
    end else begin
      state      <= next_state;
      is_wr      <= next_wr;
      ack        <= next_ack;
      stp        <= next_stp;
      hl         <= next_hl;
      hoe_n      <= next_hoe_n;
      ph         <= next_ph;
      crc        <= next_crc;
      hout       <= next_hout;
      rx_data    <= next_rxd;
      rx_valid   <= next_rxv;
      tx_take    <= next_take;
      burst_done <= next_done;
      mode_ok    <= next_ok;
    end
    dmack_pin <= next_dmack_pin;
  end

  // No task-file, memory or I/O cycles are issued by this end at all
  assign link.cs_n        = 2'h3;
  assign link.addr        = ADDR_UDMA;
  assign link.dmack       = dmack_pin;
  assign link.stop        = stp;
  assign link.hrdy_hstb   = hl;
  assign link.host_d_o    = hout;
  assign link.host_d_oe_n = hoe_n;

endmodule : udmab_host

// [tb/udmab_chk.sv]
// Purpose: Pin checks on the link between card end and host end
// Assumes: Pins carry physical levels; polarity follows iface_mode
// Notes:   iface_mode only changes under reset, so ack_on never glitches
`timescale 1ns/1ps
module udmab_chk
  import udmab_pkg::*;
(
  // Clock, reset and mode
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [1:0]  iface_mode,
  // Link pins
  input wire logic        dmarq,
  input wire logic        dmack,
  input wire logic        stop,
  input wire logic        hrdy_hstb,
  input wire logic        drdy_dstb,
  input wire logic        intrq,
  input wire logic [15:0] dev_d_o,
  input wire logic        dev_d_oe_n,
  input wire logic [15:0] host_d_o,
  input wire logic        host_d_oe_n,
  input wire logic [10:0] addr,
  input wire logic [1:0]  cs_n
);
  logic rq_on;
  logic ack_on;

  assign rq_on  = (dmarq == (iface_mode == IFM_IDE));
  assign ack_on = (dmack == (iface_mode == IFM_IO));

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sel_neg_a: assert property (ack_on |-> cs_n == 2'h3 && addr == ADDR_UDMA)
    else $error("select or address active in burst");
  ack_req_a: assert property ($rose(ack_on) |-> rq_on)
    else $error("acknowledge without request");
  one_drv_a: assert property (!(!dev_d_oe_n && !host_d_oe_n))
    else $error("both ends drive the data bus");
  dev_drv_a: assert property (!dev_d_oe_n |-> ack_on)
    else $error("card drives data outside a burst");
  dstb_setup_a: assert property (ack_on && !dev_d_oe_n && $changed(drdy_dstb)
    |-> $stable(dev_d_o) && $past(!dev_d_oe_n))
    else $error("card strobe edge without settled data");
  dstb_rate_a: assert property (ack_on && !dev_d_oe_n && $changed(drdy_dstb)
    |=> ($stable(drdy_dstb) || !rq_on) [*4])
    else $error("card strobe edges closer than one word time");
  hstb_setup_a: assert property (ack_on && !host_d_oe_n && !stop && $changed(hrdy_hstb)
    |-> $stable(host_d_o))
    else $error("host strobe edge without settled data");
  rdy_busy_a: assert property (iface_mode == IFM_MEM && rq_on |-> !intrq)
    else $error("ready line not busy during command");
  lines_back_a: assert property ($fell(ack_on)
    |-> ##[0:8] (drdy_dstb && hrdy_hstb && dev_d_oe_n))
    else $error("lines not idle after burst end");
  rst_idle_a: assert property ($fell(rst)
    |-> !rq_on && !ack_on && dev_d_oe_n && host_d_oe_n)
    else $error("link not idle after reset");
endmodule : udmab_chk

// [tb/tb.sv]
// Purpose: Bench joining card end and host end across the link
// Assumes: 200 MHz core_clk; both ends keep the hand-over contract
// Notes:   One queue of expected words serves both receive sides
`timescale 1ns/1ps
module tb;
  import udmab_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        core_clk;
  logic        rst        = 1'b1;
  logic [1:0]  iface_mode = IFM_MEM;
  logic [4:0]  ctl_v      = 5'h00;
  logic [2:0]  fm_val     = 3'h0;
  logic        cmd_write  = 1'b0;
  logic [15:0] cmd_words  = 16'h0000;
  logic [15:0] d_tx       = 16'h0000;
  logic [15:0] h_tx       = 16'h0000;
  logic [15:0] h_left     = 16'h0000;
  logic [15:0] e_left;
  logic        b_done;
  int          bursts     = 0;
  logic        d_take, h_take, d_rxv, h_rxv, busy, done, fallback, crc_err, mode_ok;
  logic [15:0] d_rx, h_rx, id_word, got;
  logic [2:0]  umode;
  logic [15:0] exp_q[$];
  int          fails      = 0;
  int          compares   = 0;
  int          rcv        = 0;

  udmab_if link ();
  udmab_device u_udmab_device (.core_clk(core_clk), .rst(rst), .link(link.dev),
    .iface_mode(iface_mode), .feat_mode_stb(ctl_v[1]), .feat_mode_val(fm_val),
    .feat_revert_dis_stb(ctl_v[2]), .feat_revert_en_stb(ctl_v[3]), .soft_rst(ctl_v[4]),
    .cmd_stb(ctl_v[0]), .cmd_write(cmd_write), .cmd_words(cmd_words), .tx_data(d_tx),
    .tx_valid(1'b1), .tx_take(d_take), .rx_data(d_rx), .rx_valid(d_rxv),
    .id_udma_word(id_word), .udma_mode(umode), .cmd_busy(busy), .cmd_done(done),
    .mdma_fallback(fallback), .crc_err(crc_err), .err_left(e_left));
  udmab_host u_udmab_host (.core_clk(core_clk), .rst(rst), .link(link.host),
    .iface_mode(iface_mode), .dev_id_word(id_word), .sel_mode(3'h4),
    .cmd_write(cmd_write), .tx_data(h_tx), .tx_valid(h_left != 16'h0000), .tx_take(h_take),
    .rx_data(h_rx), .rx_valid(h_rxv), .mode_ok(mode_ok), .burst_done(b_done));
  udmab_chk u_udmab_chk (.core_clk(core_clk), .rst(rst), .iface_mode(iface_mode),
    .dmarq(link.dmarq), .dmack(link.dmack), .stop(link.stop),
    .hrdy_hstb(link.hrdy_hstb), .drdy_dstb(link.drdy_dstb), .intrq(link.intrq),
    .dev_d_o(link.dev_d_o), .dev_d_oe_n(link.dev_d_oe_n), .host_d_o(link.host_d_o),
    .host_d_oe_n(link.host_d_oe_n), .addr(link.addr), .cs_n(link.cs_n));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // Bits: soft reset, revert enable, revert disable, mode strobe, command
  task automatic ctl(input logic [4:0] v);
    @(posedge core_clk);
    ctl_v <= v;
    @(posedge core_clk);
    ctl_v <= 5'h00;
  endtask : ctl

  task automatic set_mode(input logic [2:0] v);
    fm_val <= v;
    ctl(5'h02);
    cyc(3);
  endtask : set_mode

  task automatic hard(input logic [1:0] im);
    @(posedge core_clk);
    rst <= 1'b1;
    iface_mode <= im;
    cyc(4);
    rst <= 1'b0;
    cyc(3);
  endtask : hard

  task automatic run_cmd(input logic w, input logic [15:0] n);
    int i;
    exp_q.delete();
    rcv = 0;
    bursts = 0;
    // The host user offers exactly the words the command needs
    h_left <= w ? n : 16'h0000;
    cmd_write <= w;
    cmd_words <= n;
    ctl(5'h01);
    for (i = 0; i < 3000 && done !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    if (i == 3000) begin
      fails++;
      give_verdict();
    end
    cyc(12);
    chk("word count", n, 16'(rcv));
    chk("crc flag", 16'h0000, {15'h0, crc_err});
    chk("busy after done", 16'h0000, {15'h0, busy});
    chk("unsent words", 16'h0000, 16'(exp_q.size()));
    chk("error position", 16'h0000, e_left);
    chk("bursts", 16'h0001, 16'(bursts));
  endtask : run_cmd

  // Watcher: every received word must match the oldest word sent
  always @(posedge core_clk) begin
    got = (d_rxv === 1'b1) ? d_rx : h_rx;
    if (d_rxv === 1'b1 || h_rxv === 1'b1) begin
      rcv++;
      chk("received word", exp_q.size() > 0 ? exp_q.pop_front() : ~got, got);
    end
    if (d_take === 1'b1) begin
      exp_q.push_back(d_tx);
      d_tx <= 16'($urandom);
    end
    if (h_take === 1'b1) begin
      exp_q.push_back(h_tx);
      h_tx <= 16'($urandom);
      h_left <= h_left - 16'h0001;
    end
    if (b_done === 1'b1) begin
      bursts++;
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h21DF9483));
    cyc(20);
    rst <= 1'b0;
    cyc(3);
    chk("mode after reset", {13'h0, MODE_NONE}, {13'h0, umode});
    chk("supported modes", 16'h001F, id_word);
    cmd_words <= 16'h0004;
    ctl(5'h01);
    cyc(10);
    chk("fallback", 16'h0001, {15'h0, fallback});
    chk("no burst busy", 16'h0000, {15'h0, busy});
    $display("test no-mode refusal done");
    set_mode(3'h5);
    chk("mode above max", {13'h0, MODE_NONE}, {13'h0, umode});
    for (int m = 0; m <= 4; m++) begin
      set_mode(3'(m));
      chk("selected mode", 16'(m), {13'h0, umode});
      chk("id word", 16'(1 << (m + 8)) | 16'h001F, id_word);
    end
    chk("host mode ok", 16'h0001, {15'h0, mode_ok});
    $display("test mode select done");
    for (int im = 0; im < 3; im++) begin
      hard(2'(im));
      chk("mode cleared", {13'h0, MODE_NONE}, {13'h0, umode});
      set_mode(3'h4);
      run_cmd(1'b0, 16'h0001);
      run_cmd(1'b0, 16'(2 + $urandom % 6));
      run_cmd(1'b1, 16'(2 + $urandom % 6));
      run_cmd(1'b1, 16'h0001);
      $display("test bursts in interface mode %0d done", im);
    end
    ctl(5'h04);
    ctl(5'h10);
    cyc(3);
    chk("mode kept", 16'h0004, {13'h0, umode});
    run_cmd(1'b0, 16'h0003);
    ctl(5'h08);
    ctl(5'h10);
    cyc(3);
    chk("mode reverted", {13'h0, MODE_NONE}, {13'h0, umode});
    $display("test soft reset done");
    give_verdict();
  end
endmodule : tb
